// >>> src/fprf_pkg.sv
// Shared types and constants for the float result forwarding block.
// Assumes one core clock and reset shared with the fetch and decode stages.

package fprf_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int REG_W = 32;
    localparam int NREG = 8;
    localparam int IDX_W = 3;
    // Cycles from leaving operand_read_stage_two to the result being usable.
    localparam int RESULT_LATENCY = 3;
    // Slots a reader must trail its producer by; two independent slots between suffice.
    localparam int SAFE_GAP = 3;

    // ------------------------------------------------------------------
    // Instruction classes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_FLOAT_MULTIPLY = 3'h1,
        OP_FLOAT_ADD = 3'h2,
        OP_FLOAT_SUBTRACT = 3'h3,
        OP_FLOAT_MULTIPLY_ACCUMULATE = 3'h4,
        OP_RECIPROCAL_ESTIMATE = 3'h5,
        OP_INVERSE_SQRT_ESTIMATE = 3'h6
    } fprf_op_e;

    typedef struct packed {
        logic valid;
        fprf_op_e op;
        logic [IDX_W-1:0] dest;
        logic [IDX_W-1:0] src;
    } fprf_instr_s;

    localparam fprf_instr_s INSTR_EMPTY = '{1'b0, OP_NONE, 3'h0, 3'h0};
    localparam logic [REG_W-1:0] REG_RESET = 32'h0000_0000;

endpackage

// >>> src/fprf_stage.sv
// One pipeline stage register holding an instruction descriptor.
// Assumes the caller raises hold for every stage in the same cycle.

`timescale 1ns/100ps

module fprf_stage (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Stage control
    input wire logic hold,
    input wire fprf_pkg::fprf_instr_s d,
    output fprf_pkg::fprf_instr_s q
);

    fprf_pkg::fprf_instr_s next_q;

    always_comb begin
        // A held stage keeps its contents so nothing is lost or duplicated.
        next_q = hold ? q : d;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= fprf_pkg::INSTR_EMPTY;
        end else begin
            q <= next_q;
        end
    end

endmodule

// >>> src/fprf_top.sv
// Operand forwarding and latched flag control for the float pipeline.
// Assumes the issue port and stall come from the core, synchronous to clk.
//
// Function
// - Multiply, add, subtract and multiply-accumulate need three cycles before a reader can use their result.
// - While the third execute stage stalls, every stage holds and advances only after the stall.
// - Once the producer leaves the third execute stage, its destination holds the result and later readers take it from there.
// - The two estimate instructions give correct results but leave latched flags that cannot be trusted.
// - A reader samples its operand in its first cycle in the second read stage, forwarded if its producer is then in the third execute stage.
// - The latched underflow and overflow flags drive interrupt lines of one shared group.

`timescale 1ns/100ps

module fprf_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Issue from decode into operand_read_stage_one
    input wire fprf_pkg::fprf_instr_s issue_instr,
    // Datapath status of the instruction in execute_stage_three
    input wire logic stall_e3,
    input wire logic [fprf_pkg::REG_W-1:0] e3_result,
    input wire logic e3_underflow,
    input wire logic e3_overflow,
    // Software clear of the latched flags
    input wire logic flag_clear,
    // Operand taken in operand_read_stage_two
    output logic [fprf_pkg::REG_W-1:0] r2_operand,
    output logic r2_operand_valid,
    // Flags and interrupt lines
    output logic lat_underflow,
    output logic lat_overflow,
    output logic flags_suspect,
    output logic hazard_seen
);

    // ------------------------------------------------------------------
    // Pipeline stages
    // ------------------------------------------------------------------
    fprf_pkg::fprf_instr_s r2, e1, e2, e3;

    fprf_stage u_r2 (.clk(clk), .rst_b(rst_b), .hold(stall_e3),
        .d(issue_instr), .q(r2));
    fprf_stage u_e1 (.clk(clk), .rst_b(rst_b), .hold(stall_e3),
        .d(r2), .q(e1));
    fprf_stage u_e2 (.clk(clk), .rst_b(rst_b), .hold(stall_e3),
        .d(e1), .q(e2));
    fprf_stage u_e3 (.clk(clk), .rst_b(rst_b), .hold(stall_e3),
        .d(e2), .q(e3));

    function automatic logic is_estimate(input fprf_pkg::fprf_op_e op);
        return (op == fprf_pkg::OP_RECIPROCAL_ESTIMATE) ||
            (op == fprf_pkg::OP_INVERSE_SQRT_ESTIMATE);
    endfunction

    // ------------------------------------------------------------------
    // Result registers and operand sampling
    // ------------------------------------------------------------------
    logic [fprf_pkg::REG_W-1:0] reg_file [fprf_pkg::NREG];
    logic [fprf_pkg::REG_W-1:0] next_reg_file [fprf_pkg::NREG];
    logic r2_fresh, next_r2_fresh;
    logic [fprf_pkg::REG_W-1:0] next_r2_operand;
    logic next_r2_operand_valid;
    logic e3_leaves, fwd_hit, next_hazard_seen;

    assign e3_leaves = e3.valid && !stall_e3;
    assign fwd_hit = e3.valid && (e3.dest == r2.src);

    always_comb begin
        next_reg_file = reg_file;
        // The destination is written only as the producer leaves E3.
        if (e3_leaves) begin
            next_reg_file[e3.dest] = e3_result;
        end
        // Freshness marks the single cycle in which the reader samples.
        next_r2_fresh = stall_e3 ? 1'b0 : issue_instr.valid;
        next_r2_operand = r2_operand;
        next_r2_operand_valid = r2_operand_valid;
        if (r2_fresh) begin
            // The forward path is taken even under stall; the register
            // only receives the result when E3 is left.
            next_r2_operand = fwd_hit ? e3_result :
                reg_file[r2.src];
            next_r2_operand_valid = 1'b1;
        end else if (!stall_e3) begin
            next_r2_operand_valid = 1'b0;
        end
        // A reader one or two slots behind its producer broke the gap.
        next_hazard_seen = r2_fresh && (
            (e1.valid && (e1.dest == r2.src)) ||
            (e2.valid && (e2.dest == r2.src)));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < fprf_pkg::NREG; i++) begin
                reg_file[i] <= fprf_pkg::REG_RESET;
            end
            r2_fresh <= 1'b0;
            r2_operand <= fprf_pkg::REG_RESET;
            r2_operand_valid <= 1'b0;
            hazard_seen <= 1'b0;
        end else begin
            reg_file <= next_reg_file;
            r2_fresh <= next_r2_fresh;
            r2_operand <= next_r2_operand;
            r2_operand_valid <= next_r2_operand_valid;
            hazard_seen <= next_hazard_seen;
        end
    end

    // ------------------------------------------------------------------
    // Latched flags
    // ------------------------------------------------------------------
    logic next_lat_underflow, next_lat_overflow, next_flags_suspect;
    logic set_uf, set_ov;

    assign set_uf = e3_leaves && e3_underflow;
    assign set_ov = e3_leaves && e3_overflow;

    always_comb begin
        // A set in the clearing cycle wins so no event is dropped.
        next_lat_underflow = set_uf || (lat_underflow && !flag_clear);
        next_lat_overflow = set_ov || (lat_overflow && !flag_clear);
        // Estimate instructions may raise flags that mean nothing; the
        // suspect bit lets software tell them apart from real events.
        next_flags_suspect = (e3_leaves && is_estimate(e3.op)) ||
            (flags_suspect && !flag_clear);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lat_underflow <= 1'b0;
            lat_overflow <= 1'b0;
            flags_suspect <= 1'b0;
        end else begin
            lat_underflow <= next_lat_underflow;
            lat_overflow <= next_lat_overflow;
            flags_suspect <= next_flags_suspect;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    stage_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        stall_e3 |=> (e3 == $past(e3)) && (r2 == $past(r2)))
        else $error("Pipeline moved during a stall.");

    result_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        e3_leaves |=> reg_file[$past(e3.dest)] == $past(e3_result))
        else $error("Result not in destination after leaving E3.");

    stalled_forward_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r2_fresh && fwd_hit && stall_e3) |=> r2_operand == $past(e3_result))
        else $error("Stalled producer was not forwarded.");

    register_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r2_fresh && !fwd_hit) |=> r2_operand == $past(reg_file[r2.src]))
        else $error("Reader did not take the register value.");

    single_sample_a: assert property (@(posedge clk) disable iff (!rst_b)
        !r2_fresh |=> $stable(r2_operand))
        else $error("Operand resampled after entering R2.");

    flag_set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
        (flag_clear && set_ov) |=> lat_overflow)
        else $error("Overflow event lost against a clear.");

    estimate_suspect_a: assert property (@(posedge clk) disable iff (!rst_b)
        (e3_leaves && is_estimate(e3.op)) |=> flags_suspect)
        else $error("Estimate did not mark the flags suspect.");

    gap_hazard_a: assert property (@(posedge clk) disable iff (!rst_b)
        (r2_fresh && e1.valid && (e1.dest == r2.src)) |=> hazard_seen)
        else $error("Short producer gap not reported.");

endmodule

// >>> sim/fprf_core_model.sv
// Issue source standing in for the core's fetch and decode stages.
// Assumes the bench hands it at most one instruction per cycle on cmd.
`timescale 1ns/100ps
module fprf_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request from the bench and the pipeline stall
    input wire logic cmd_valid,
    input wire fprf_pkg::fprf_instr_s cmd,
    input wire logic stall_e3,
    // Issue port
    output fprf_pkg::fprf_instr_s issue_instr
);
    // A bubble flips its unused fields so nothing can lean on stale ones.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            issue_instr <= fprf_pkg::INSTR_EMPTY;
        end else if (!stall_e3) begin
            issue_instr <= cmd_valid ? cmd : '{1'b0, fprf_pkg::OP_NONE,
                ~issue_instr.dest, ~issue_instr.src};
        end
    end
endmodule

// >>> sim/test_fprf_top.sv
// Self-checking bench for the float result forwarding block.
// Assumes the issue source model sits between the bench and issue_instr.
`timescale 1ns/100ps
module test_fprf_top;
    logic clk, rst_b, stall_e3, flag_clear, cmd_valid;
    logic e3_underflow, e3_overflow, r2_operand_valid, hazard_seen;
    logic lat_underflow, lat_overflow, flags_suspect;
    logic [fprf_pkg::REG_W-1:0] e3_result, r2_operand;
    fprf_pkg::fprf_instr_s cmd, issue_instr;
    int num_errors, checks;

    fprf_core_model core (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd(cmd), .stall_e3(stall_e3), .issue_instr(issue_instr));
    fprf_top uut (.clk(clk), .rst_b(rst_b), .issue_instr(issue_instr),
        .stall_e3(stall_e3), .e3_result(e3_result),
        .e3_underflow(e3_underflow), .e3_overflow(e3_overflow),
        .flag_clear(flag_clear), .r2_operand(r2_operand),
        .r2_operand_valid(r2_operand_valid), .lat_underflow(lat_underflow),
        .lat_overflow(lat_overflow), .flags_suspect(flags_suspect),
        .hazard_seen(hazard_seen));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Producer writes register 6, a reader of register 6 follows after gap
    // bubbles. The stall holds the producer one extra cycle in E3, and the
    // result bus is inverted once it leaves so a late forward shows up.
    task automatic fwd_case(input fprf_pkg::fprf_op_e op, input int gap,
                            input logic stall, input logic [31:0] v);
        logic haz;
        int nval;
        haz = 1'b0;
        nval = 0;
        for (int c = 0; c < 16; c++) begin
            cmd_valid <= (c == 0 || c == gap + 1);
            cmd <= (c == 0) ? '{1'b1, op, 3'h6, 3'h1}
                : '{1'b1, fprf_pkg::OP_FLOAT_ADD, 3'h2, 3'h6};
            stall_e3 <= stall && c == 5;
            e3_result <= (c < 6 + stall) ? v : ~v;
            @(posedge clk);
            if (hazard_seen === 1'b1) haz = 1'b1;
            if (r2_operand_valid === 1'b1) nval++;
        end
        check(haz, gap < 2);
        check(nval, 2);
        if (gap >= 2) check(r2_operand, v);
        $display("operand test op %0d gap %0d stall %0b done", op, gap, stall);
    endtask

    // An op raises both flags as it leaves E3; software then clears them.
    // With clash set, a clear lands in the very cycle of the event.
    task automatic flag_case(input fprf_pkg::fprf_op_e op, input logic clash);
        for (int c = 0; c < 10; c++) begin
            cmd_valid <= (c == 0);
            flag_clear <= clash && (c == 5);
            cmd <= '{1'b1, op, 3'h4, 3'h0};
            e3_overflow <= (c == 5);
            e3_underflow <= (c == 5);
            @(posedge clk);
        end
        check(lat_overflow, 1'b1);
        check(lat_underflow, 1'b1);
        check(flags_suspect, op == fprf_pkg::OP_RECIPROCAL_ESTIMATE ||
              op == fprf_pkg::OP_INVERSE_SQRT_ESTIMATE);
        flag_clear <= 1'b1;
        @(posedge clk);
        flag_clear <= 1'b0;
        @(posedge clk);
        check({lat_overflow, lat_underflow, flags_suspect}, 3'h0);
        $display("flag test op %0d done", op);
    endtask

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        stall_e3 = 1'b0;
        flag_clear = 1'b0;
        cmd_valid = 1'b0;
        cmd = fprf_pkg::INSTR_EMPTY;
        e3_result = 32'h0;
        e3_underflow = 1'b0;
        e3_overflow = 1'b0;
        num_errors = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({lat_overflow, lat_underflow, hazard_seen}, 3'h0);
        fwd_case(fprf_pkg::OP_FLOAT_MULTIPLY, 2, 1'b0, 32'h1111_0001);
        fwd_case(fprf_pkg::OP_FLOAT_ADD, 2, 1'b0, 32'h2222_0002);
        fwd_case(fprf_pkg::OP_FLOAT_SUBTRACT, 2, 1'b1, 32'h3333_0003);
        fwd_case(fprf_pkg::OP_FLOAT_MULTIPLY_ACCUMULATE, 3, 1'b1,
                 32'h4444_0004);
        fwd_case(fprf_pkg::OP_FLOAT_MULTIPLY, 3, 1'b0, 32'h5555_0005);
        fwd_case(fprf_pkg::OP_FLOAT_MULTIPLY, 1, 1'b0, 32'h6666_0006);
        fwd_case(fprf_pkg::OP_FLOAT_ADD, 0, 1'b0, 32'h7777_0007);
        flag_case(fprf_pkg::OP_RECIPROCAL_ESTIMATE, 1'b0);
        flag_case(fprf_pkg::OP_INVERSE_SQRT_ESTIMATE, 1'b0);
        flag_case(fprf_pkg::OP_FLOAT_ADD, 1'b0);
        flag_case(fprf_pkg::OP_FLOAT_MULTIPLY, 1'b1);
        give_verdict();
    end
endmodule
